// ==== logic/path_parser_pkg.sv ====
package path_parser_pkg;

  // ==========================================================================
  // Characters
  // ==========================================================================
  localparam logic [7:0] CH_NL    = 8'h0a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_STAR  = 8'h2a;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI  = 8'h3b;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_A_UP  = 8'h41;
  localparam logic [7:0] CH_Z_UP  = 8'h5a;
  localparam logic [7:0] CH_A_LO  = 8'h61;
  localparam logic [7:0] CH_Z_LO  = 8'h7a;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // ==========================================================================
  // Keyword packing
  // ==========================================================================
  localparam logic [2:0]  KEY_CHARS = 3'h4;
  localparam logic [2:0]  KEY_SHORT = 3'h3;
  localparam logic [3:0]  ERR_MAX   = 4'hf;

  // Keywords, upper case, right aligned.
  localparam logic [31:0] KW_ABOR = 32'h41424f52;
  localparam logic [31:0] KW_TRIG = 32'h54524947;
  localparam logic [31:0] KW_SOUR = 32'h534f5552;
  localparam logic [31:0] KW_DEL  = 32'h0044454c;
  localparam logic [31:0] KW_DELA = 32'h44454c41;
  localparam logic [31:0] KW_IMM  = 32'h00494d4d;
  localparam logic [31:0] KW_IMME = 32'h494d4d45;
  localparam logic [31:0] KW_SYST = 32'h53595354;
  localparam logic [31:0] KW_ERR  = 32'h00455252;
  localparam logic [31:0] KW_ERRO = 32'h4552524f;
  localparam logic [31:0] KW_PRES = 32'h50524553;
  localparam logic [31:0] KW_STAT = 32'h53544154;
  localparam logic [31:0] KW_FREQ = 32'h46524551;
  localparam logic [31:0] KW_SENS = 32'h53454e53;
  localparam logic [31:0] KW_AVER = 32'h41564552;
  localparam logic [31:0] KW_COUN = 32'h434f554e;

  // Three-letter parameter and common-command codes.
  localparam logic [23:0] PK_BUS = 24'h425553;
  localparam logic [23:0] PK_EXT = 24'h455854;
  localparam logic [23:0] PK_MAN = 24'h4d414e;
  localparam logic [23:0] PK_INT = 24'h494e54;
  localparam logic [23:0] CC_RST = 24'h525354;
  localparam logic [23:0] CC_CLS = 24'h434c53;

  // ==========================================================================
  // Command tree nodes
  // ==========================================================================
  localparam logic [3:0] N_ROOT      = 4'h0;
  localparam logic [3:0] N_TRIG      = 4'h1;
  localparam logic [3:0] N_TRIG_SOUR = 4'h2;
  localparam logic [3:0] N_TRIG_DEL  = 4'h3;
  localparam logic [3:0] N_TRIG_IMM  = 4'h4;
  localparam logic [3:0] N_SYST      = 4'h5;
  localparam logic [3:0] N_SYST_ERR  = 4'h6;
  localparam logic [3:0] N_SYST_PRES = 4'h7;
  localparam logic [3:0] N_STAT      = 4'h8;
  localparam logic [3:0] N_STAT_PRES = 4'h9;
  localparam logic [3:0] N_SOUR      = 4'ha;
  localparam logic [3:0] N_SOUR_FREQ = 4'hb;
  localparam logic [3:0] N_SENS      = 4'hc;
  localparam logic [3:0] N_SENS_AVER = 4'hd;
  localparam logic [3:0] N_AVER_COUN = 4'he;
  localparam logic [3:0] N_ABOR      = 4'hf;

  typedef enum logic [1:0] {
    TS_BUS = 2'b00,
    TS_EXT = 2'b01,
    TS_MAN = 2'b10,
    TS_INT = 2'b11
  } trig_src_e;

  localparam trig_src_e TRIG_SRC_RESET = TS_INT;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_KEY    = 3'b001,
    ST_LOOK   = 3'b010,
    ST_TAKE   = 3'b011,
    ST_PARAM  = 3'b100,
    ST_SKIP   = 3'b101,
    ST_COMMON = 3'b110
  } parse_st_e;

  typedef enum logic [2:0] {
    D_COLON = 3'b000,
    D_SEMI  = 3'b001,
    D_SPACE = 3'b010,
    D_QUERY = 3'b011,
    D_TERM  = 3'b100
  } delim_e;

endpackage

// ==== logic/key_lookup_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface key_lookup_if;
  logic        req;
  logic [3:0]  parent;
  logic [31:0] key;
  logic        hit;
  logic [3:0]  node;

  modport parser (output req, output parent, output key, input hit, input node);
  modport table_side (input req, input parent, input key, output hit, output node);
endinterface
`default_nettype wire

// ==== logic/key_lookup.sv ====
`timescale 1ns/10ps
`default_nettype none
module key_lookup
  import path_parser_pkg::*;
(
  // Clock and reset.
  input wire logic         i_clk,
  input wire logic         i_reset_n,
  // Lookup port.
  key_lookup_if.table_side lk
);

  // ==========================================================================
  // Tree table
  // ==========================================================================
  function automatic logic [4:0] child_of(input logic [3:0] p, input logic [31:0] k);
    logic [4:0] r;
    r = {1'b0, N_ROOT};
    case (p)
      N_ROOT: begin
        if (k == KW_ABOR) r = {1'b1, N_ABOR};
        if (k == KW_TRIG) r = {1'b1, N_TRIG};
        if (k == KW_SYST) r = {1'b1, N_SYST};
        if (k == KW_STAT) r = {1'b1, N_STAT};
        if (k == KW_SOUR) r = {1'b1, N_SOUR};
        if (k == KW_SENS) r = {1'b1, N_SENS};
      end
      N_TRIG: begin
        if (k == KW_SOUR) r = {1'b1, N_TRIG_SOUR};
        if (k == KW_DEL || k == KW_DELA) r = {1'b1, N_TRIG_DEL};
        if (k == KW_IMM || k == KW_IMME) r = {1'b1, N_TRIG_IMM};
      end
      N_SYST: begin
        if (k == KW_ERR || k == KW_ERRO) r = {1'b1, N_SYST_ERR};
        if (k == KW_PRES) r = {1'b1, N_SYST_PRES};
      end
      N_STAT: begin
        if (k == KW_PRES) r = {1'b1, N_STAT_PRES};
      end
      N_SOUR: begin
        if (k == KW_FREQ) r = {1'b1, N_SOUR_FREQ};
      end
      N_SENS: begin
        if (k == KW_AVER) r = {1'b1, N_SENS_AVER};
      end
      N_SENS_AVER: begin
        if (k == KW_COUN) r = {1'b1, N_AVER_COUN};
      end
      default: r = {1'b0, N_ROOT};
    endcase
    return r;
  endfunction

  wire logic [4:0] result;
  assign result = child_of(lk.parent, lk.key);

  // Result is registered: it is valid the cycle after the request.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lk.hit  <= 1'b0;
      lk.node <= N_ROOT;
    end else if (lk.req) begin
      lk.hit  <= result[4];
      lk.node <= result[3:0];
    end
  end

endmodule
`default_nettype wire

// ==== logic/path_message_parser.sv ====
// What this block does
// - After reset and after the reset common command the current path is the root.
// - Any message terminator returns the current path to the root before the next message.
// - A colon between two keywords descends one level below the preceding keyword.
// - A colon that starts a command makes its keywords resolve from the root.
// - A semicolon ends one command and starts the next at the level of the last keyword of a resolved command.
// - Asterisk commands are taken the same at any path and, except the reset command, leave the path as it was.
// - Upper and lower case letters are equal in keywords and character parameters.
// - Newline, end-of-identify on the last byte, or both together all end a message.
// - The trigger source setting selects bus, external, manual or internal triggering.
`timescale 1ns/10ps
`default_nettype none
module path_message_parser
  import path_parser_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET_N,
  // Received bytes from the bus interface.
  input  wire logic [7:0]  I_DATA,
  input  wire logic        I_VALID,
  input  wire logic        I_EOI,
  output var  logic        O_READY,
  // Decoded commands.
  output var  logic        O_CMD_VALID,
  output var  logic [3:0]  O_CMD_NODE,
  output var  logic        O_CMD_QUERY,
  output var  logic        O_COMMON_VALID,
  output var  logic [23:0] O_COMMON_CODE,
  // Parser state.
  output var  logic [3:0]  O_PATH_NODE,
  output var  logic [1:0]  O_TRIG_SRC,
  output var  logic [3:0]  O_ERR_CNT
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= CH_A_LO && c <= CH_Z_LO) ? (c & ~CASE_BIT) : c;
  endfunction
  function automatic logic [31:0] append(input logic [31:0] k, input logic [2:0] n, input logic [7:0] c);
    return (n < KEY_CHARS) ? {k[23:0], c} : k;
  endfunction
  function automatic logic [2:0] bump(input logic [2:0] n);
    return (n < KEY_CHARS) ? 3'(n + 3'h1) : n;
  endfunction
  function automatic logic [23:0] first3(input logic [31:0] k, input logic [2:0] n);
    return (n == KEY_CHARS) ? k[31:8] : k[23:0];
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  parse_st_e   state_r, state_nxt;
  delim_e      pend_r, pend_nxt;
  logic [3:0]  cur_r, cur_nxt;
  logic [3:0]  walk_r, walk_nxt;
  logic [3:0]  last_par_r, last_par_nxt;
  logic [31:0] key_r, key_nxt;
  logic [2:0]  kcnt_r, kcnt_nxt;
  logic [31:0] pkey_r, pkey_nxt;
  logic [2:0]  pcnt_r, pcnt_nxt;
  logic        query_r, query_nxt;
  trig_src_e   trig_r, trig_nxt;
  logic [3:0]  err_r, err_nxt;
  logic        cmd_v_nxt;
  logic        com_v_nxt;
  logic [23:0] com_code_nxt;
  key_lookup_if lk ();
  key_lookup u_lookup (
    .i_clk     (I_MCLK),
    .i_reset_n (I_RESET_N),
    .lk        (lk)
  );
  // ==========================================================================
  // Byte decode
  // ==========================================================================
  wire logic [7:0]  ch;
  wire logic        acc;
  wire logic        letter;
  wire logic        term;
  wire logic        ends_cmd;
  wire logic [31:0] key_app;
  wire logic [31:0] pkey_app;
  wire logic [2:0]  pcnt_app;
  wire logic [23:0] param3;
  wire delim_e      delim;
  wire logic        is_delim;
  assign ch       = upcase(I_DATA);
  assign acc      = I_VALID && O_READY;
  assign letter   = ch >= CH_A_UP && ch <= CH_Z_UP;
  // Three terminator forms; EOI rides on the final data byte.
  assign term     = (I_DATA == CH_NL) || I_EOI;
  assign ends_cmd = term || I_DATA == CH_SEMI;
  assign key_app  = letter ? append(key_r, kcnt_r, ch) : key_r;
  assign pkey_app = letter ? append(pkey_r, pcnt_r, ch) : pkey_r;
  assign pcnt_app = letter ? bump(pcnt_r) : pcnt_r;
  assign param3   = first3(pkey_app, pcnt_app);
  assign delim    = I_EOI ? D_TERM :
                    I_DATA == CH_NL ? D_TERM :
                    I_DATA == CH_COLON ? D_COLON :
                    I_DATA == CH_SEMI ? D_SEMI :
                    I_DATA == CH_QUERY ? D_QUERY : D_SPACE;
  assign is_delim = term || I_DATA == CH_COLON || I_DATA == CH_SEMI || I_DATA == CH_QUERY || I_DATA == CH_SPACE;
  assign lk.req    = state_r == ST_LOOK;
  assign lk.parent = walk_r;
  assign lk.key    = key_r;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_nxt    = state_r;
    pend_nxt     = pend_r;
    cur_nxt      = cur_r;
    walk_nxt     = walk_r;
    last_par_nxt = last_par_r;
    key_nxt      = key_r;
    kcnt_nxt     = kcnt_r;
    pkey_nxt     = pkey_r;
    pcnt_nxt     = pcnt_r;
    query_nxt    = query_r;
    trig_nxt     = trig_r;
    err_nxt      = err_r;
    cmd_v_nxt    = 1'b0;
    com_v_nxt    = 1'b0;
    com_code_nxt = O_COMMON_CODE;
    case (state_r)
      ST_IDLE: begin
        if (acc) begin
          key_nxt  = {24'h000000, ch};
          kcnt_nxt = 3'h1;
          if (I_DATA == CH_STAR) begin
            key_nxt   = 32'h00000000;
            kcnt_nxt  = 3'h0;
            state_nxt = I_EOI ? ST_IDLE : ST_COMMON;
          end else if (I_DATA == CH_COLON) begin
            // Leading colon restarts from the root.
            walk_nxt  = N_ROOT;
            key_nxt   = 32'h00000000;
            kcnt_nxt  = 3'h0;
            state_nxt = I_EOI ? ST_IDLE : ST_KEY;
          end else if (letter) begin
            walk_nxt  = cur_r;
            pend_nxt  = D_TERM;
            state_nxt = I_EOI ? ST_LOOK : ST_KEY;
          end
          // A terminator on an empty command still resets the path.
          if (term) begin
            cur_nxt = N_ROOT;
          end
        end
      end
      ST_KEY: begin
        if (acc) begin
          key_nxt  = key_app;
          kcnt_nxt = letter ? bump(kcnt_r) : kcnt_r;
          if (is_delim) begin
            pend_nxt  = delim;
            state_nxt = ST_LOOK;
          end
        end
      end
      ST_LOOK: begin
        state_nxt = ST_TAKE;
      end
      ST_TAKE: begin
        key_nxt   = 32'h00000000;
        kcnt_nxt  = 3'h0;
        pkey_nxt  = 32'h00000000;
        pcnt_nxt  = 3'h0;
        query_nxt = pend_r == D_QUERY;
        if (!lk.hit) begin
          // Count the error and drop the rest of the command.
          err_nxt   = (err_r == ERR_MAX) ? err_r : 4'(err_r + 4'h1);
          state_nxt = (pend_r == D_SEMI || pend_r == D_TERM) ? ST_IDLE : ST_SKIP;
          if (pend_r == D_TERM) begin
            cur_nxt = N_ROOT;
          end
        end else begin
          last_par_nxt = walk_r;
          walk_nxt     = lk.node;
          case (pend_r)
            // Descend one level below the keyword just resolved.
            D_COLON: state_nxt = ST_KEY;
            D_SPACE: state_nxt = ST_PARAM;
            D_QUERY: state_nxt = ST_PARAM;
            default: begin
              cmd_v_nxt = 1'b1;
              state_nxt = ST_IDLE;
              // After a semicolon the path stays at the level of the last keyword; a terminator sends it to the root.
              cur_nxt   = (pend_r == D_TERM) ? N_ROOT : walk_r;
            end
          endcase
        end
      end
      ST_PARAM: begin
        if (acc) begin
          pkey_nxt = pkey_app;
          pcnt_nxt = pcnt_app;
          if (ends_cmd) begin
            cmd_v_nxt = 1'b1;
            state_nxt = ST_IDLE;
            cur_nxt   = term ? N_ROOT : last_par_r;
            if (walk_r == N_TRIG_SOUR && !query_r) begin
              if (param3 == PK_BUS) trig_nxt = TS_BUS;
              else if (param3 == PK_EXT) trig_nxt = TS_EXT;
              else if (param3 == PK_MAN) trig_nxt = TS_MAN;
              else if (param3 == PK_INT) trig_nxt = TS_INT;
              else err_nxt = (err_r == ERR_MAX) ? err_r : 4'(err_r + 4'h1);
            end
          end
        end
      end
      ST_SKIP: begin
        if (acc && ends_cmd) begin
          state_nxt = ST_IDLE;
          cur_nxt   = term ? N_ROOT : cur_r;
        end
      end
      ST_COMMON: begin
        if (acc) begin
          key_nxt  = key_app;
          kcnt_nxt = letter ? bump(kcnt_r) : kcnt_r;
          if (ends_cmd) begin
            // Common commands other than the reset command do not touch the current path.
            com_v_nxt    = 1'b1;
            com_code_nxt = key_app[23:0];
            state_nxt    = ST_IDLE;
            cur_nxt      = term ? N_ROOT : cur_r;
            // Reset command returns to the root.
            if (key_app[23:0] == CC_RST) begin
              cur_nxt  = N_ROOT;
              trig_nxt = TRIG_SRC_RESET;
            end
            if (key_app[23:0] == CC_CLS) begin
              err_nxt = 4'h0;
            end
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  // ==========================================================================
  // Registers
  // ==========================================================================
  // Power-up places the path at the root.
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_r        <= ST_IDLE;
      pend_r         <= D_TERM;
      cur_r          <= N_ROOT;
      walk_r         <= N_ROOT;
      last_par_r     <= N_ROOT;
      key_r          <= 32'h00000000;
      kcnt_r         <= 3'h0;
      pkey_r         <= 32'h00000000;
      pcnt_r         <= 3'h0;
      query_r        <= 1'b0;
      trig_r         <= TRIG_SRC_RESET;
      err_r          <= 4'h0;
      O_READY        <= 1'b1;
      O_CMD_VALID    <= 1'b0;
      O_COMMON_VALID <= 1'b0;
      O_COMMON_CODE  <= 24'h000000;
    end else begin
      state_r        <= state_nxt;
      pend_r         <= pend_nxt;
      cur_r          <= cur_nxt;
      walk_r         <= walk_nxt;
      last_par_r     <= last_par_nxt;
      key_r          <= key_nxt;
      kcnt_r         <= kcnt_nxt;
      pkey_r         <= pkey_nxt;
      pcnt_r         <= pcnt_nxt;
      query_r        <= query_nxt;
      trig_r         <= trig_nxt;
      err_r          <= err_nxt;
      O_READY        <= state_nxt != ST_LOOK && state_nxt != ST_TAKE;
      O_CMD_VALID    <= cmd_v_nxt;
      O_COMMON_VALID <= com_v_nxt;
      O_COMMON_CODE  <= com_code_nxt;
    end
  end

  assign O_CMD_NODE  = walk_r;
  assign O_CMD_QUERY = query_r;
  assign O_PATH_NODE = cur_r;
  assign O_TRIG_SRC  = trig_r;
  assign O_ERR_CNT   = err_r;

endmodule
`default_nettype wire

// ==== testbench/path_message_parser_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module path_message_parser_assertions
  import path_parser_pkg::*;
(
  // Clock and reset.
  input wire logic        I_MCLK,
  input wire logic        I_RESET_N,
  // Received bytes.
  input wire logic [7:0]  I_DATA,
  input wire logic        I_VALID,
  input wire logic        I_EOI,
  input wire logic        O_READY,
  // Decoded commands.
  input wire logic        O_CMD_VALID,
  input wire logic [3:0]  O_CMD_NODE,
  input wire logic        O_CMD_QUERY,
  input wire logic        O_COMMON_VALID,
  input wire logic [23:0] O_COMMON_CODE,
  // Parser state.
  input wire logic [3:0]  O_PATH_NODE,
  input wire logic [1:0]  O_TRIG_SRC,
  input wire logic [3:0]  O_ERR_CNT
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  // ==========================================================================
  // Path, trigger and error state, lookup stall and output pulses
  // ==========================================================================
  AST_RESET_ROOT: assert property (
    $rose(I_RESET_N) |-> O_PATH_NODE == N_ROOT && O_TRIG_SRC == TRIG_SRC_RESET && O_ERR_CNT == 4'h0)
    else $error("state after reset is not root and defaults");
  AST_RST_ROOT: assert property (
    O_COMMON_VALID && O_COMMON_CODE == CC_RST |-> O_PATH_NODE == N_ROOT && O_TRIG_SRC == TRIG_SRC_RESET)
    else $error("reset command left path or trigger source");
  AST_TERM_ROOT: assert property (
    I_VALID && O_READY && (I_DATA == CH_NL || I_EOI) |-> ##[1:4] O_PATH_NODE == N_ROOT)
    else $error("path not at root after terminator");
  AST_LOOKUP_GAP: assert property (
    $fell(O_READY) |=> !O_READY ##1 O_READY)
    else $error("keyword lookup stall is not two cycles");
  AST_CMD_PULSE: assert property (
    O_CMD_VALID |=> !O_CMD_VALID)
    else $error("command pulse longer than one cycle");
  AST_COMMON_PULSE: assert property (
    O_COMMON_VALID |=> !O_COMMON_VALID)
    else $error("common pulse longer than one cycle");
  AST_TRIG_CAUSE: assert property (
    !$stable(O_TRIG_SRC) |-> (O_CMD_VALID && O_CMD_NODE == N_TRIG_SOUR && !O_CMD_QUERY)
                             || (O_COMMON_VALID && O_COMMON_CODE == CC_RST))
    else $error("trigger source changed without a setting command");
  AST_QUERY_KEEPS: assert property (
    O_CMD_VALID && O_CMD_QUERY |-> $stable(O_TRIG_SRC))
    else $error("query changed trigger source");
  AST_ERR_STEP: assert property (
    !$stable(O_ERR_CNT) |-> O_ERR_CNT == $past(O_ERR_CNT) + 4'h1 || O_ERR_CNT == 4'h0)
    else $error("error count moved by more than one");
endmodule

bind path_message_parser path_message_parser_assertions u_path_message_parser_assertions (
  .I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_DATA(I_DATA), .I_VALID(I_VALID), .I_EOI(I_EOI),
  .O_READY(O_READY), .O_CMD_VALID(O_CMD_VALID), .O_CMD_NODE(O_CMD_NODE), .O_CMD_QUERY(O_CMD_QUERY),
  .O_COMMON_VALID(O_COMMON_VALID), .O_COMMON_CODE(O_COMMON_CODE), .O_PATH_NODE(O_PATH_NODE),
  .O_TRIG_SRC(O_TRIG_SRC), .O_ERR_CNT(O_ERR_CNT)
);
`default_nettype wire

// ==== testbench/host_bus_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  // Clock and handshake.
  input  wire logic       i_clk,
  input  wire logic       i_ready,
  // Byte lines towards the parser.
  output var  logic [7:0] o_data,
  output var  logic       o_valid,
  output var  logic       o_eoi
);
  logic rdy_s;

  initial begin
    o_data  = 8'h00;
    o_valid = 1'b0;
    o_eoi   = 1'b0;
  end

  // Ready seen at the falling edge is the value that the next rising edge samples.
  always @(negedge i_clk) rdy_s = i_ready;

  task automatic send(input string s, input logic eoi_last);
    @(posedge i_clk);
    for (int i = 0; i < s.len(); i++) begin
      o_data  <= s[i];
      o_valid <= 1'b1;
      o_eoi   <= eoi_last && (i == s.len() - 1);
      @(posedge i_clk);
      while (rdy_s !== 1'b1) @(posedge i_clk);
    end
    o_valid <= 1'b0;
    o_eoi   <= 1'b0;
    // Released lines show the inverse of the last byte, never a stale copy.
    o_data  <= ~o_data;
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_scpi_path_message_parser.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_scpi_path_message_parser;
  import path_parser_pkg::*;

  logic        mclk;
  logic        reset_n;
  logic [7:0]  data;
  logic        valid;
  logic        eoi;
  logic        ready;
  logic        cmd_valid;
  logic [3:0]  cmd_node;
  logic        cmd_query;
  logic        common_valid;
  logic [23:0] common_code;
  logic [3:0]  path_node;
  logic [1:0]  trig_src;
  logic [3:0]  err_cnt;
  logic [3:0]  nodes[$];
  logic        queries[$];
  int          n_common;
  int          n_mismatch;
  int          checked;
  int          cycles;

  path_message_parser u_path_message_parser (
    .I_MCLK(mclk), .I_RESET_N(reset_n), .I_DATA(data), .I_VALID(valid), .I_EOI(eoi), .O_READY(ready),
    .O_CMD_VALID(cmd_valid), .O_CMD_NODE(cmd_node), .O_CMD_QUERY(cmd_query),
    .O_COMMON_VALID(common_valid), .O_COMMON_CODE(common_code), .O_PATH_NODE(path_node),
    .O_TRIG_SRC(trig_src), .O_ERR_CNT(err_cnt)
  );

  host_bus_model u_host_bus_model (
    .i_clk(mclk), .i_ready(ready), .o_data(data), .o_valid(valid), .o_eoi(eoi)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ==========================================================================
  // Monitor and timeout
  // ==========================================================================
  always @(negedge mclk) begin
    if (cmd_valid === 1'b1) begin
      nodes.push_back(cmd_node);
      queries.push_back(cmd_query);
    end
    if (common_valid === 1'b1) n_common++;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic msg(input string s, input logic eoi_last);
    nodes.delete();
    queries.delete();
    n_common = 0;
    u_host_bus_model.send(s, eoi_last);
    repeat (6) @(posedge mclk);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    check(path_node, N_ROOT, "path after reset");
    check(trig_src, TRIG_SRC_RESET, "trigger source after reset");
    check(err_cnt, 0, "error count after reset");
    check(ready, 1, "ready after reset");
  endtask

  task automatic t_sources();
    string s[4];
    logic  e[4];
    s = '{"TRIG:SOUR BUS\n", "trig:sour ext", "Trig:Sour Man\n", "tRiG:sOuR iNt\n"};
    e = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      msg(s[i], e[i]);
      check(trig_src, i, "trigger source");
      check(nodes.size(), 1, "command count");
      check(nodes[0], N_TRIG_SOUR, "descended node");
      check(path_node, N_ROOT, "path after terminator form");
    end
  endtask

  task automatic t_root();
    msg("TRIG:DEL 1\n", 1'b0);
    msg("SOUR:FREQ 1\n", 1'b0);
    check(nodes[0], N_SOUR_FREQ, "next message starts at root");
  endtask

  task automatic t_colon_semi();
    msg(":SENS:AVER:COUN 4;COUN 5;:SYST:ERR?\n", 1'b0);
    check(nodes.size(), 3, "chained command count");
    check(nodes[0], N_AVER_COUN, "three level node");
    check(nodes[1], N_AVER_COUN, "same level after semicolon");
    check(nodes[2], N_SYST_ERR, "leading colon from root");
    check({queries[0], queries[2]}, 2'b01, "query flags");
  endtask

  task automatic t_error();
    msg("FOO 1;:TRIG:SOUR MAN\n", 1'b0);
    check(err_cnt, 1, "error counted");
    check(nodes.size(), 1, "bad command dropped");
    check(trig_src, TS_MAN, "command after bad one runs");
  endtask

  task automatic t_bare();
    msg("ABOR;TRIG:IMM;DEL 1\n", 1'b0);
    check(nodes.size(), 3, "bare keyword commands");
    check(nodes[0], N_ABOR, "keyword ended by semicolon");
    check(nodes[1], N_TRIG_IMM, "short form keyword");
    check(nodes[2], N_TRIG_DEL, "level kept after bare keyword");
    msg("STAT:PRES", 1'b1);
    check(nodes[0], N_STAT_PRES, "keyword ended by end-of-identify");
    check(path_node, N_ROOT, "path after bare terminator");
  endtask

  task automatic t_common();
    msg("TRIG:SOUR BUS;*CLS;SOUR EXT\n", 1'b0);
    check(n_common, 1, "common pulse");
    check(common_code, CC_CLS, "common code");
    check(err_cnt, 0, "error count cleared");
    check(nodes[1], N_TRIG_SOUR, "path kept across common");
    check(trig_src, TS_EXT, "source after common");
  endtask

  task automatic t_rst();
    msg("TRIG:SOUR MAN;*rst;SOUR BUS", 1'b1);
    check(common_code, CC_RST, "lower case common");
    check(trig_src, TRIG_SRC_RESET, "reset command source");
    check(nodes[1], N_SOUR, "keyword after reset command from root");
    check(path_node, N_ROOT, "reset command path");
    msg("TRIG:SOUR BUS;BAD\n", 1'b0);
    check(err_cnt, 1, "error before second reset");
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    check(trig_src, TRIG_SRC_RESET, "source after second reset");
    check(path_node, N_ROOT, "path after second reset");
    check(err_cnt, 0, "error count after second reset");
  endtask

  initial begin
    reset_n    = 1'b0;
    n_mismatch = 0;
    checked    = 0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_sources();
    t_root();
    t_colon_semi();
    t_error();
    t_bare();
    t_common();
    t_rst();
    finish_test();
  end
endmodule
`default_nettype wire
